//--- rtl/flash_rd_pkg.sv
// shared opcodes, command decode and lane helpers for the serial nor read path
package flash_rd_pkg;

  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_STATUS = 8'h05;

  // wrap setting is {wrap disable, length[1:0]}
  localparam logic [2:0] WRAP_RESET = 3'h4;
  localparam int WRAP_DIS_POS = 2;
  localparam int WRAP_FIELD_LSB = 4;
  localparam logic [3:0] MODE_UPPER = 4'hf;
  localparam logic [4:0] CMD_CLOCKS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [3:0] LONG_DUMMY = 4'h8;
  localparam logic [3:0] QUAD_IO_DUMMY = 4'h4;
  localparam logic [2:0] DIV_HIGH_START = 3'h4;
  localparam logic [2:0] DIV_RELEASE = 3'h6;
  localparam logic [2:0] DIV_LAST = 3'h7;
  localparam logic [4:0] TAIL_CYCLES = 5'h06;

  typedef enum logic [2:0] {CMD, ADDR, MODE, DUMMY, DATA, HALT, IDLE, TAIL} phase_t;

  typedef struct packed {
    logic valid;
    logic array;
    logic quad;
    logic wrap;
    logic [4:0] addrClk;
    logic [2:0] modeClk;
    logic [3:0] dumClk;
    logic [2:0] inW;
    logic [2:0] outW;
  } cmd_cfg_t;

  function automatic cmd_cfg_t decode(input logic [7:0] op);
    cmd_cfg_t c;
    c = '0;
    c.valid = 1'b1;
    c.array = 1'b1;
    c.addrClk = ADDR_BITS;
    c.inW = 3'h1;
    c.outW = 3'h1;
    case (op)
      OP_READ: ;
      OP_FAST: c.dumClk = LONG_DUMMY;
      OP_DUAL_OUT: begin
        c.dumClk = LONG_DUMMY;
        c.outW = 3'h2;
      end
      OP_QUAD_OUT: begin
        c.dumClk = LONG_DUMMY;
        c.outW = 3'h4;
        c.quad = 1'b1;
      end
      OP_DUAL_IO: begin
        c.addrClk = 5'h0c;
        c.modeClk = 3'h4;
        c.inW = 3'h2;
        c.outW = 3'h2;
      end
      OP_QUAD_IO: begin
        c.addrClk = 5'h06;
        c.modeClk = 3'h2;
        c.dumClk = QUAD_IO_DUMMY;
        c.inW = 3'h4;
        c.outW = 3'h4;
        c.quad = 1'b1;
      end
      OP_SET_WRAP: begin
        c.addrClk = 5'h06;
        c.modeClk = 3'h2;
        c.inW = 3'h4;
        c.outW = 3'h0;
        c.array = 1'b0;
        c.wrap = 1'b1;
      end
      OP_STATUS: begin
        c.addrClk = 5'h00;
        c.array = 1'b0;
      end
      default: c = '0;
    endcase
    return c;
  endfunction : decode

  function automatic phase_t nextPhase(input phase_t p, input cmd_cfg_t c);
    phase_t n;
    n = HALT;
    case (p)
      CMD: n = !c.valid ? HALT : (c.addrClk != 5'h00) ? ADDR : DATA;
      ADDR: n = (c.modeClk != 3'h0) ? MODE : (c.dumClk != 4'h0) ? DUMMY : DATA;
      MODE: n = c.wrap ? HALT : (c.dumClk != 4'h0) ? DUMMY : DATA;
      DUMMY: n = DATA;
      default: n = HALT;
    endcase
    return n;
  endfunction : nextPhase

  function automatic logic [2:0] laneOf(input phase_t p, input cmd_cfg_t c);
    case (p)
      ADDR, MODE: return c.inW;
      DATA: return c.outW;
      default: return 3'h1;
    endcase
  endfunction : laneOf

  // clocks in a phase; for data it is clocks per byte
  function automatic logic [4:0] phaseLen(input phase_t p, input cmd_cfg_t c);
    case (p)
      CMD: return CMD_CLOCKS;
      ADDR: return c.addrClk;
      MODE: return {2'b00, c.modeClk};
      DUMMY: return {1'b0, c.dumClk};
      DATA: return (c.outW == 3'h1) ? 5'h08 : (c.outW == 3'h2) ? 5'h04 : 5'h02;
      default: return 5'h01;
    endcase
  endfunction : phaseLen

  // single-lane traffic runs host-to-device on io0, device-to-host on io1
  function automatic logic [3:0] laneMask(input logic [2:0] w, input logic fromDev);
    case (w)
      3'h1: return fromDev ? 4'h2 : 4'h1;
      3'h2: return 4'h3;
      3'h4: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction : laneMask

  function automatic logic [3:0] pickIn(input logic [3:0] io, input logic [2:0] w,
                                        input logic fromDev);
    if (w == 3'h1) return {3'b000, fromDev ? io[1] : io[0]};
    return io & laneMask(w, fromDev);
  endfunction : pickIn

  function automatic logic [23:0] shiftIn(input logic [23:0] v, input logic [3:0] b,
                                          input logic [2:0] w);
    case (w)
      3'h2: return {v[21:0], b[1:0]};
      3'h4: return {v[19:0], b[3:0]};
      default: return {v[22:0], b[0]};
    endcase
  endfunction : shiftIn

endpackage : flash_rd_pkg

//--- rtl/spi_link_if.sv
// shared four-line serial link between host controller and flash die
`timescale 1ns/1ps
interface spi_link_if;
  logic csN;
  logic sclk;
  logic [3:0] hostIoOut;
  logic [3:0] hostIoOe;
  logic [3:0] devIoOut;
  logic [3:0] devIoOe;
  logic [3:0] io;

  // undriven lines float high through pull-ups
  assign io = (hostIoOe & hostIoOut) | (~hostIoOe & devIoOe & devIoOut) |
              ~(hostIoOe | devIoOe);

  modport host (output csN, output sclk, output hostIoOut, output hostIoOe, input io);
  modport dev (input csN, input sclk, input io, output devIoOut, output devIoOe);
endinterface : spi_link_if

//--- rtl/serial_nor_read_dev.sv
// flash die end: read commands, status read and burst wrap setting
`timescale 1ns/1ps
// Operation
// RULE_01 - read opcode then 24-bit address, rising edge
// RULE_02 - data changes on falling edge, msb first
// RULE_03 - address advances per byte until select rises
// RULE_04 - plain read ignored while busy
// RULE_05 - fast read has eight dummy clocks
// RULE_06 - dual output: eight dummies, two bits per clock
// RULE_07 - host releases data lines before data
// RULE_08 - quad output needs quad permit bit
// RULE_09 - dual io: address and data two lines
// RULE_10 - mode byte upper nibble sent as ones
// RULE_11 - quad io: four lines, four dummies, permit
// RULE_12 - set wrap: opcode, 24 dummies, wrap byte
// RULE_13 - disable bit and length select 8..64
// RULE_14 - wrapped quad io stays inside aligned section
// RULE_15 - wrap setting kept until next set wrap
// RULE_16 - wrap disabled after reset
// RULE_17 - status byte repeats, unchanged, msb first
// RULE_18 - select high ends command, releases lines
module serial_nor_read_dev
  import flash_rd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic quadPermit,
  input wire logic busy,
  output logic [23:0] memAddr,
  input wire logic [7:0] memData,
  output logic [2:0] wrapSetting,
  spi_link_if.dev link
);

  typedef struct packed {
    phase_t phase;
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] mode;
    logic wrapDone;
    logic [4:0] syncA;
    logic [4:0] syncB;
  } link_st_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pin_st_t;

  typedef struct packed {
    logic [2:0] wrapSet;
    logic [2:0] doneSync;
  } sys_st_t;

  localparam sys_st_t SYS_RESET = '{wrapSet: WRAP_RESET, doneSync: 3'h0};

  link_st_t ln_q;
  link_st_t ln_d;
  pin_st_t pn_q;
  pin_st_t pn_d;
  sys_st_t sy_q;
  sys_st_t sy_d;

  cmd_cfg_t cfg;
  cmd_cfg_t newCfg;
  logic [2:0] lanes;
  logic [4:0] len;
  logic last;
  logic [3:0] inBits;
  logic qeSync;
  logic busySync;
  logic [2:0] wrapSync;
  logic wrapOn;
  logic [7:0] outByte;

  // step inside the aligned section when wrapping, else across the whole array
  function automatic logic [23:0] nextAddr(input logic [23:0] a, input logic on,
                                           input logic [1:0] sel);
    logic [23:0] m;
    logic [23:0] inc;
    m = (24'h000008 << sel) - 24'h000001;
    inc = a + 24'h000001;
    if (on) return (a & ~m) | (inc & m); // [RULE_14]
    return inc; // [RULE_03]
  endfunction : nextAddr

  // pick the beat's bits of a byte and place them on the output lines
  function automatic logic [3:0] slice(input logic [7:0] b, input logic [2:0] w,
                                       input logic [4:0] beat);
    logic [7:0] sh;
    sh = b << (beat * w);
    case (w)
      3'h1: return {2'b00, sh[7], 1'b0};
      3'h2: return {2'b00, sh[7:6]};
      default: return sh[7:4];
    endcase
  endfunction : slice

  assign cfg = decode(ln_q.cmd);
  assign lanes = laneOf(ln_q.phase, cfg);
  assign len = phaseLen(ln_q.phase, cfg);
  assign last = ln_q.cnt == len - 5'h01;
  assign inBits = pickIn(link.io, lanes, 1'b0);
  assign qeSync = ln_q.syncB[4];
  assign busySync = ln_q.syncB[3];
  assign wrapSync = ln_q.syncB[2:0];
  // wrap only applies to quad io reads, and only while the disable bit is clear
  assign wrapOn = ln_q.cmd == OP_QUAD_IO && !wrapSync[WRAP_DIS_POS]; // [RULE_13] [RULE_15]
  // status read never alters state; only the busy flag is reported
  assign outByte = cfg.array ? memData : {7'h00, busySync}; // [RULE_17]

  always_comb begin
    ln_d = ln_q;
    newCfg = decode({ln_q.cmd[6:0], inBits[0]});
    ln_d.syncA = {quadPermit, busy, sy_q.wrapSet};
    ln_d.syncB = ln_q.syncA;
    unique case (ln_q.phase)
      CMD: begin
        ln_d.cmd = {ln_q.cmd[6:0], inBits[0]}; // [RULE_01]
        ln_d.cnt = ln_q.cnt + 5'h01;
        if (last) begin
          ln_d.cnt = 5'h00;
          ln_d.phase = nextPhase(CMD, newCfg);
          if (newCfg.array && busySync) begin
            ln_d.phase = HALT; // [RULE_04]
          end
          if (newCfg.quad && !qeSync) begin
            ln_d.phase = HALT; // [RULE_08] [RULE_11]
          end
        end
      end
      ADDR, MODE, DUMMY: begin
        if (ln_q.phase == ADDR) begin
          ln_d.addr = shiftIn(ln_q.addr, inBits, lanes); // [RULE_01] [RULE_09] [RULE_11]
        end
        if (ln_q.phase == MODE) begin
          // mode bits are taken but continuous mode is not entered
          ln_d.mode = 8'(shiftIn({16'h0000, ln_q.mode}, inBits, lanes)); // [RULE_10] [RULE_12]
        end
        ln_d.cnt = ln_q.cnt + 5'h01;
        if (last) begin
          ln_d.cnt = 5'h00;
          ln_d.phase = nextPhase(ln_q.phase, cfg); // [RULE_05] [RULE_06] [RULE_11]
          if (ln_q.phase == MODE && cfg.wrap) begin
            ln_d.wrapDone = 1'b1; // [RULE_12]
          end
        end
      end
      DATA: begin
        ln_d.cnt = ln_q.cnt + 5'h01;
        if (last) begin
          ln_d.cnt = 5'h00;
          if (cfg.array) begin
            ln_d.addr = nextAddr(ln_q.addr, wrapOn, wrapSync[1:0]); // [RULE_03] [RULE_14]
          end
        end
      end
      HALT, IDLE, TAIL: ;
    endcase
  end

  // select high clears the whole frame at once, with no clock needed
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      ln_q <= '0; // [RULE_18]
    end else begin
      ln_q <= ln_d;
    end
  end

  always_comb begin
    pn_d = '0;
    if (ln_q.phase == DATA) begin
      pn_d.oe = laneMask(cfg.outW, 1'b1); // [RULE_06] [RULE_08] [RULE_09]
      pn_d.out = slice(outByte, cfg.outW, ln_q.cnt); // [RULE_02] [RULE_17]
    end
  end

  // lines change on the falling edge so the bit is settled through the high phase, when the host samples it
  always_ff @(negedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      pn_q <= '0; // [RULE_18]
    end else begin
      pn_q <= pn_d; // [RULE_02]
    end
  end

  assign link.devIoOut = pn_q.out;
  assign link.devIoOe = pn_q.oe;
  assign memAddr = ln_q.addr;

  // the wrap byte is held until select rises, so the flag edge can fetch it safely
  always_comb begin
    sy_d = sy_q;
    sy_d.doneSync = {sy_q.doneSync[1:0], ln_q.wrapDone};
    if (sy_q.doneSync[1] && !sy_q.doneSync[2]) begin
      // stored as {disable, length}: the byte carries length above the disable bit
      sy_d.wrapSet = {ln_q.mode[WRAP_FIELD_LSB], ln_q.mode[WRAP_FIELD_LSB + 1 +: 2]}; // [RULE_13]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sy_q <= SYS_RESET; // [RULE_16]
    end else if (clkEn) begin
      sy_q <= sy_d;
    end
  end

  assign wrapSetting = sy_q.wrapSet;

endmodule : serial_nor_read_dev

//--- rtl/serial_nor_read_host.sv
// host controller end: frames read and set-wrap commands, makes the link clock
`timescale 1ns/1ps
module serial_nor_read_host
  import flash_rd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [7:0] cmdOp,
  input wire logic [23:0] addr,
  input wire logic [7:0] argByte,
  input wire logic [7:0] byteCount,
  output logic ready,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic done,
  spi_link_if.host link
);

  typedef struct packed {
    phase_t phase;
    logic [2:0] div;
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [39:0] tx;
    logic [7:0] rx;
    logic [7:0] left;
    logic [3:0] s1;
    logic [3:0] s2;
    logic csN;
    logic sclk;
    logic [3:0] out;
    logic [3:0] oe;
    logic [7:0] rdData;
    logic rdValid;
    logic done;
  } host_st_t;

  localparam host_st_t HOST_RESET = '{phase: IDLE, csN: 1'b1, default: '0};

  host_st_t h_q;
  host_st_t h_d;
  cmd_cfg_t cfg;
  cmd_cfg_t startCfg;
  logic [2:0] lanes;
  logic [2:0] nLanes;
  logic last;
  logic [7:0] rxNew;

  assign cfg = decode(h_q.cmd);
  assign startCfg = decode(cmdOp);
  assign lanes = laneOf(h_q.phase, cfg);
  assign last = h_q.cnt == phaseLen(h_q.phase, cfg) - 5'h01;
  assign rxNew = 8'(shiftIn({16'h0000, h_q.rx}, pickIn(h_q.s2, lanes, 1'b1), lanes));

  always_comb begin
    h_d = h_q;
    nLanes = 3'h1;
    h_d.rdValid = 1'b0;
    h_d.done = 1'b0;
    h_d.s1 = link.io;
    h_d.s2 = h_q.s1;
    unique case (h_q.phase)
      IDLE: begin
        if (start) begin
          h_d.cmd = cmdOp;
          // set-wrap sends zero dummies; reads force the mode byte's upper nibble high
          h_d.tx = startCfg.wrap ? {cmdOp, 24'h000000, argByte} // [RULE_12]
                                 : {cmdOp, addr, MODE_UPPER, argByte[3:0]}; // [RULE_10]
          h_d.left = byteCount;
          h_d.csN = 1'b0;
          h_d.div = 3'h0;
          h_d.cnt = 5'h00;
          h_d.phase = CMD;
          h_d.out = {3'b000, cmdOp[7]}; // [RULE_01]
          h_d.oe = 4'h1;
        end
      end
      HALT: h_d.phase = TAIL;
      TAIL: begin
        h_d.sclk = 1'b0;
        h_d.oe = 4'h0;
        h_d.cnt = h_q.cnt + 5'h01;
        if (h_q.cnt == TAIL_CYCLES) begin
          h_d.csN = 1'b1;
          h_d.done = 1'b1;
          h_d.phase = IDLE;
        end
      end
      CMD, ADDR, MODE, DUMMY, DATA: begin
        h_d.div = h_q.div + 3'h1;
        h_d.sclk = h_d.div >= DIV_HIGH_START;
        // free the lines after the last driven rise, before the device's first fall
        if (h_q.div == DIV_RELEASE && last && h_q.phase != DATA &&
            nextPhase(h_q.phase, cfg) inside {DUMMY, DATA}) begin
          h_d.oe = 4'h0; // [RULE_07]
        end
        if (h_q.div == DIV_LAST) begin
          h_d.cnt = last ? 5'h00 : h_q.cnt + 5'h01;
          if (h_q.phase inside {CMD, ADDR, MODE}) begin
            h_d.tx = h_q.tx << lanes; // [RULE_09]
          end
          if (h_q.phase == DATA) begin
            h_d.rx = rxNew;
            if (last) begin
              h_d.rdData = rxNew;
              h_d.rdValid = 1'b1;
              h_d.left = h_q.left - 8'h01;
              if (h_q.left <= 8'h01) begin
                h_d.phase = TAIL;
              end
            end
          end else if (last) begin
            h_d.phase = nextPhase(h_q.phase, cfg) == HALT ? TAIL : nextPhase(h_q.phase, cfg);
          end
          h_d.out = 4'h0;
          h_d.oe = 4'h0;
          if (h_d.phase inside {CMD, ADDR, MODE}) begin
            nLanes = laneOf(h_d.phase, cfg);
            h_d.oe = laneMask(nLanes, 1'b0);
            h_d.out = (nLanes == 3'h4) ? h_d.tx[39:36] :
                      (nLanes == 3'h2) ? {2'b00, h_d.tx[39:38]} : {3'b000, h_d.tx[39]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      h_q <= HOST_RESET;
    end else if (clkEn) begin
      h_q <= h_d;
    end
  end

  assign link.csN = h_q.csN;
  assign link.sclk = h_q.sclk;
  assign link.hostIoOut = h_q.out;
  assign link.hostIoOe = h_q.oe;
  assign ready = h_q.phase == IDLE;
  assign rdData = h_q.rdData;
  assign rdValid = h_q.rdValid;
  assign done = h_q.done;

endmodule : serial_nor_read_host

//--- bench/flash_rd_sva.sv
// link checker: framing, clock shape and line ownership between the two ends
`timescale 1ns/1ps
module flash_rd_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] hostIoOut,
  input wire logic [3:0] hostIoOe,
  input wire logic [3:0] devIoOut,
  input wire logic [3:0] devIoOe,
  input wire logic [3:0] io
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  no_contention_a: assert property ((hostIoOe & devIoOe) == 4'h0)
    else $error("both ends drive a line");
  idle_release_a: assert property (csN && $past(csN) |-> devIoOe == 4'h0)
    else $error("flash drives while deselected");
  idle_clock_a: assert property (csN |-> !sclk)
    else $error("link clock high while deselected");
  frame_lead_a: assert property ($fell(csN) |-> (!sclk)[*4] ##1 sclk)
    else $error("first link clock misplaced");
  out_on_fall_a: assert property (!csN && $changed(devIoOut) |-> $fell(sclk))
    else $error("flash output moved off the falling edge");
  clock_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high phase wrong");
  clock_low_a: assert property ($fell(sclk) && !csN |-> (!sclk)[*4])
    else $error("link clock low phase short");
  line_resolve_a: assert property ((io & hostIoOe) == (hostIoOut & hostIoOe) && (io | hostIoOe | devIoOe) == 4'hf)
    else $error("link lines resolve wrongly");
  lane_set_a: assert property (devIoOe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal flash lane set");
  cmd_quiet_a: assert property ($fell(csN) |-> (devIoOe == 4'h0)[*8])
    else $error("flash drives during opcode");

  quad_out_c: cover property (devIoOe == 4'hf);
  dual_out_c: cover property (devIoOe == 4'h3);
  single_out_c: cover property (devIoOe == 4'h2);
  frame_end_c: cover property ($rose(csN));
endmodule : flash_rd_sva

//--- bench/tb.sv
// bench: host and flash ends joined over the link, streamed bytes against a model
`timescale 1ns/1ps
module tb;
  import flash_rd_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic quadPermit = 1'b1;
  logic busy = 1'b0;
  logic start = 1'b0;
  logic [7:0] cmdOp = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [7:0] argByte = 8'h00;
  logic [7:0] byteCount = 8'h01;
  logic ready, rdValid, done;
  logic [7:0] rdData;
  logic [23:0] memAddr;
  logic [7:0] memData;
  logic [2:0] wrapSetting;
  logic [7:0] expQ[$];
  logic [7:0] rdOps[6] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT, OP_DUAL_IO, OP_QUAD_IO};
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h4e54adff;
  int wrapOn = 0;
  int wrapLen = 8;
  logic [23:0] a;
  logic [7:0] arg;

  spi_link_if link ();
  serial_nor_read_host u_serial_nor_read_host (.sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1),
    .start(start), .cmdOp(cmdOp), .addr(addr), .argByte(argByte), .byteCount(byteCount),
    .ready(ready), .rdData(rdData), .rdValid(rdValid), .done(done), .link(link));
  serial_nor_read_dev u_serial_nor_read_dev (.sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1),
    .quadPermit(quadPermit), .busy(busy), .memAddr(memAddr), .memData(memData),
    .wrapSetting(wrapSetting), .link(link));
  flash_rd_sva u_flash_rd_sva (.sys_clk(sys_clk), .rstn(rstn), .csN(link.csN), .sclk(link.sclk),
    .hostIoOut(link.hostIoOut), .hostIoOe(link.hostIoOe), .devIoOut(link.devIoOut),
    .devIoOe(link.devIoOe), .io(link.io));

  always #20 sys_clk = ~sys_clk;

  // array contents mix all address bytes so a wrong address shows up
  function automatic logic [7:0] memOf(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3c;
  endfunction : memOf
  assign memData = memOf(memAddr);

  task automatic stop_test();
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // hang guard: the whole sequence needs well under half of this
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // reference stream; wrapping applies to quad io reads only
  task automatic model(input logic [7:0] op, input logic [23:0] s, input int n);
    int i;
    expQ = {};
    for (i = 0; i < n; i++) begin
      if (op == OP_QUAD_IO && wrapOn != 0)
        expQ.push_back(memOf({s[23:8], 8'((s[7:0] / wrapLen) * wrapLen +
          (s[7:0] + i) % wrapLen)}));
      else expQ.push_back(memOf(s + 24'(i)));
    end
  endtask : model

  task automatic fill(input logic [7:0] v, input int n);
    expQ = {};
    repeat (n) expQ.push_back(v);
  endtask : fill

  task automatic run(input logic [7:0] op, input logic [23:0] s, input logic [7:0] g,
                     input int n);
    int k;
    int got;
    k = 0;
    got = 0;
    while (ready !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    @(posedge sys_clk);
    start <= 1'b1;
    cmdOp <= op;
    addr <= s;
    argByte <= g;
    byteCount <= 8'(n);
    @(posedge sys_clk);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      @(negedge sys_clk);
      k++;
      if (rdValid === 1'b1) begin
        if (got < expQ.size()) check(rdData, expQ[got]);
        got++;
      end
    end
    check(done, 1'b1);
    check(got, expQ.size());
  endtask : run

  task automatic set_wrap(input logic [7:0] g);
    expQ = {};
    run(OP_SET_WRAP, 24'($random(seed)), g, 1);
    repeat (5) @(negedge sys_clk);
    check(wrapSetting, {g[4], g[6:5]});
    wrapOn = g[4] ? 0 : 1;
    wrapLen = 8 << g[6:5];
  endtask : set_wrap

  initial begin
    int j;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    check(wrapSetting, WRAP_RESET);
    for (j = 0; j < 6; j++) begin
      a = 24'($random(seed));
      arg = 8'($random(seed));
      model(rdOps[j], a, 3);
      run(rdOps[j], a, arg, 3);
    end
    model(OP_READ, 24'hfffffe, 4);
    run(OP_READ, 24'hfffffe, 8'h00, 4);
    // bit 7 and the low nibble are random: the flash must ignore them
    for (j = 0; j < 4; j++) begin
      set_wrap({1'($random(seed)), 2'(j), 1'b0, 4'($random(seed))});
      a = {16'($random(seed)), 8'(8 * j + 5)};
      model(OP_QUAD_IO, a, wrapLen + 3);
      run(OP_QUAD_IO, a, 8'h0a, wrapLen + 3);
    end
    model(OP_QUAD_OUT, 24'h0012fe, 4);
    run(OP_QUAD_OUT, 24'h0012fe, 8'h00, 4);
    set_wrap(8'h30);
    model(OP_QUAD_IO, 24'h4567fd, 6);
    run(OP_QUAD_IO, 24'h4567fd, 8'h05, 6);
    @(posedge sys_clk);
    quadPermit <= 1'b0;
    fill(8'hff, 2);
    run(OP_QUAD_OUT, 24'h000100, 8'h00, 2);
    run(OP_QUAD_IO, 24'h000100, 8'h00, 2);
    @(posedge sys_clk);
    quadPermit <= 1'b1;
    busy <= 1'b1;
    run(OP_READ, 24'h000200, 8'h00, 2);
    fill(8'h01, 3);
    run(OP_STATUS, 24'h000000, 8'h00, 3);
    @(posedge sys_clk);
    busy <= 1'b0;
    fill(8'h00, 2);
    run(OP_STATUS, 24'h000000, 8'h00, 2);
    expQ = {};
    run(8'h9f, 24'h000000, 8'h00, 1);
    model(OP_FAST, 24'h00abcd, 2);
    run(OP_FAST, 24'h00abcd, 8'h00, 2);
    stop_test();
  end
endmodule : tb
